//--- hcs_defs.svh
`ifndef HCS_DEFS_SVH
`define HCS_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define HCS_STATUS_CMD_OFFSET 8'hf8
`define HCS_CFG_ACTIVE_BIT 0
`define HCS_SOFT_RESET_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HCS_BYTE_RST 8'h00
`define HCS_PORTS_RST 4'h0
`define HCS_CNT_RST 4'h0
`define HCS_BIT_RST 1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HCS_CLK_MHZ 40
`define HCS_RELOAD_TIME_NS 100
// Least time, so round up to whole cycles
`define HCS_RELOAD_CYCLES \
    ((`HCS_RELOAD_TIME_NS * `HCS_CLK_MHZ + 999) / 1000)

`endif

//--- hcs_pkg.sv
`default_nettype none
package hcs_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        HCS_ST_SAMPLE = 2'b00,
        HCS_ST_RUN = 2'b01,
        HCS_ST_RELOAD = 2'b10
    } hcs_state_e;

    // ------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------
    typedef struct packed
    {
        hcs_state_e st;
        logic [3:0] cnt;
        logic soft_reset;
        logic cfg_active;
        logic [7:0] rdata;
        logic rvalid;
        logic connect_en;
        logic reload;
        logic pol;
        logic individual;
        logic full_mgmt;
        logic [3:0] batt_en;
        logic [3:0] pwr_en;
    } hcs_state_s;

endpackage
`default_nettype wire

//--- hcs_top.sv

`timescale 1ns/10ps
`default_nettype none
`include "hcs_defs.svh"

module hcs_top
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic CFG_MODE_ENTER_IN,
    input wire logic SHARED_POWER_SWITCH_SEL_IN,
    input wire logic PORT_POWER_MGMT_N_IN,
    input wire logic [3:0] BATTERY_CHARGE_STRAP_IN,
    input wire logic POWER_ENABLE_POLARITY_IN,
    input wire logic [3:0] PORT_POWER_REQ_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    output logic UPSTREAM_CONNECT_EN_OUT,
    output logic CFG_RELOAD_OUT,
    output logic [3:0] PORT_POWER_ENABLE_OUT,
    output logic [3:0] BATTERY_CHARGE_EN_OUT,
    output logic INDIVIDUAL_POWER_OUT,
    output logic FULL_POWER_MGMT_OUT
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Address decode, shared by the read and the write path
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == `HCS_STATUS_CMD_OFFSET);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hcs_pkg::hcs_state_s cur;
    hcs_pkg::hcs_state_s next_cur;

    logic wr_hit;
    logic rd_hit;
    logic set_req;
    logic clr_req;
    logic [3:0] cnt_last;

    // Strobes decoded against the single mapped register
    assign wr_hit = REG_WR_IN & reg_hit(REG_ADDR_IN);
    assign rd_hit = REG_RD_IN & reg_hit(REG_ADDR_IN);
    assign set_req = wr_hit & REG_WDATA_IN[`HCS_SOFT_RESET_BIT];
    assign clr_req = wr_hit & REG_WDATA_IN[`HCS_CFG_ACTIVE_BIT];
    assign cnt_last = 4'(`HCS_RELOAD_CYCLES - 1);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // One pass computes the complete next state of the block
    always_comb
    begin
        logic [3:0] req;
        logic [3:0] on_lvl;
        req = `HCS_PORTS_RST;
        on_lvl = `HCS_PORTS_RST;
        next_cur = cur;
        next_cur.rvalid = 1'b0;

        // Read returns the value before any write in the same cycle
        if (REG_RD_IN)
        begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata = `HCS_BYTE_RST;
            if (rd_hit)
            begin
                next_cur.rdata[`HCS_SOFT_RESET_BIT] = cur.soft_reset;
                next_cur.rdata[`HCS_CFG_ACTIVE_BIT] = cur.cfg_active;
            end
        end

        // Set beats clear, so a mode entry is never lost to a host write
        next_cur.cfg_active = (cur.cfg_active & ~clr_req)
            | CFG_MODE_ENTER_IN;

        // Connect only once the flag is known to be low
        next_cur.connect_en = ~next_cur.cfg_active;

        case (cur.st)
            hcs_pkg::HCS_ST_SAMPLE:
            begin
                // Straps are caught after reset release, never by reset
                next_cur.pol = POWER_ENABLE_POLARITY_IN;
                next_cur.individual = ~SHARED_POWER_SWITCH_SEL_IN;
                next_cur.full_mgmt = ~PORT_POWER_MGMT_N_IN;
                next_cur.batt_en = BATTERY_CHARGE_STRAP_IN;
                next_cur.st = hcs_pkg::HCS_ST_RUN;
            end
            hcs_pkg::HCS_ST_RUN:
            begin
                if (set_req)
                begin
                    next_cur.soft_reset = 1'b1;
                    next_cur.reload = 1'b1;
                    next_cur.cnt = `HCS_CNT_RST;
                    next_cur.st = hcs_pkg::HCS_ST_RELOAD;
                    // Configuration except the polarity strap returns to its reset contents
                    next_cur.individual = `HCS_BIT_RST;
                    next_cur.full_mgmt = `HCS_BIT_RST;
                    next_cur.batt_en = `HCS_PORTS_RST;
                end
            end
            hcs_pkg::HCS_ST_RELOAD:
            begin
                // Further writes of one are absorbed by the running reload
                if (cur.cnt == cnt_last)
                begin
                    next_cur.soft_reset = 1'b0;
                    next_cur.reload = 1'b0;
                    next_cur.cnt = `HCS_CNT_RST;
                    // Straps are taken again, as after a global reset
                    next_cur.st = hcs_pkg::HCS_ST_SAMPLE;
                end
                else
                begin
                    next_cur.cnt = cur.cnt + 4'h1;
                end
            end
            default:
            begin
                next_cur.st = hcs_pkg::HCS_ST_SAMPLE;
            end
        endcase

        // Shared_power_switch_sel mode powers every port from any request
        if (next_cur.individual)
        begin
            req = PORT_POWER_REQ_IN;
        end
        else
        begin
            req = {4{|PORT_POWER_REQ_IN}};
        end

        // Without power management ports stay powered
        if (!next_cur.full_mgmt)
        begin
            req = 4'hf;
        end

        // Nothing is powered in reload; after reset the enables sit low, on for an active-low strap, until the straps settle
        if (next_cur.st != hcs_pkg::HCS_ST_RUN)
        begin
            req = `HCS_PORTS_RST;
        end

        // Polarity folds in last so the request logic stays one form
        on_lvl = {4{next_cur.pol}};
        next_cur.pwr_en = ~(req ^ on_lvl);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Reset loads constants only; straps follow in the sample state
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            cur.st <= hcs_pkg::HCS_ST_SAMPLE;
            cur.cnt <= `HCS_CNT_RST;
            cur.soft_reset <= `HCS_BIT_RST;
            cur.cfg_active <= `HCS_BIT_RST;
            cur.rdata <= `HCS_BYTE_RST;
            cur.rvalid <= `HCS_BIT_RST;
            cur.connect_en <= `HCS_BIT_RST;
            cur.reload <= `HCS_BIT_RST;
            cur.pol <= `HCS_BIT_RST;
            cur.individual <= `HCS_BIT_RST;
            cur.full_mgmt <= `HCS_BIT_RST;
            cur.batt_en <= `HCS_PORTS_RST;
            cur.pwr_en <= `HCS_PORTS_RST;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Every output is a field of the state register
    assign REG_RDATA_OUT = cur.rdata;
    assign REG_RVALID_OUT = cur.rvalid;
    assign UPSTREAM_CONNECT_EN_OUT = cur.connect_en;
    assign CFG_RELOAD_OUT = cur.reload;
    assign PORT_POWER_ENABLE_OUT = cur.pwr_en;
    assign BATTERY_CHARGE_EN_OUT = cur.batt_en;
    assign INDIVIDUAL_POWER_OUT = cur.individual;
    assign FULL_POWER_MGMT_OUT = cur.full_mgmt;

endmodule

`default_nettype wire

//--- hcs_top_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// Status/command checker
// ----------
module hcs_top_chk
(
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic CFG_MODE_ENTER_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic UPSTREAM_CONNECT_EN_OUT,
    input wire logic CFG_RELOAD_OUT,
    input wire logic [3:0] BATTERY_CHARGE_EN_OUT,
    input wire logic INDIVIDUAL_POWER_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Strobes aimed at the status/command byte
    wire logic wr_f8 = REG_WR_IN && REG_ADDR_IN == 8'hf8;
    wire logic rd_f8 = REG_RD_IN && REG_ADDR_IN == 8'hf8;
    chk_rsvd_zero: assert property (rd_f8 |=>
        REG_RDATA_OUT[7:2] == 6'h00)
        else $error("reserved bits read nonzero");
    // Writes right after reset or a reload land in the sampling state
    chk_reload_start: assert property (wr_f8 && REG_WDATA_IN[1] &&
        !CFG_RELOAD_OUT && !$past(CFG_RELOAD_OUT) && !$past(RST_IN)
        |=> CFG_RELOAD_OUT) else $error("soft reset did not start");
    chk_reload_defaults: assert property ($rose(CFG_RELOAD_OUT) |->
        !INDIVIDUAL_POWER_OUT && BATTERY_CHARGE_EN_OUT == 4'h0)
        else $error("reload kept strap config");
    chk_reload_length: assert property ($rose(CFG_RELOAD_OUT) |->
        CFG_RELOAD_OUT[*4] ##1 !CFG_RELOAD_OUT) else $error("bad reload");
    chk_soft_reads: assert property (rd_f8 && CFG_RELOAD_OUT |=>
        REG_RDATA_OUT[1]) else $error("soft reset bit low in reload");
    chk_enter_blocks: assert property (CFG_MODE_ENTER_IN |=>
        !UPSTREAM_CONNECT_EN_OUT) else $error("connect while active");
    chk_clear_conn: assert property (wr_f8 && REG_WDATA_IN[0] &&
        !CFG_MODE_ENTER_IN |=> UPSTREAM_CONNECT_EN_OUT)
        else $error("clear did not release");
    chk_zero_keeps: assert property (wr_f8 && !REG_WDATA_IN[0] &&
        !UPSTREAM_CONNECT_EN_OUT && !$past(RST_IN)
        |=> !UPSTREAM_CONNECT_EN_OUT) else $error("zero write cleared");
    cover property ($rose(CFG_RELOAD_OUT));
    cover property (rd_f8 && CFG_RELOAD_OUT);
    cover property (CFG_MODE_ENTER_IN);
endmodule
bind hcs_top hcs_top_chk i_hcs_top_chk
(
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .CFG_MODE_ENTER_IN(CFG_MODE_ENTER_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .CFG_RELOAD_OUT(CFG_RELOAD_OUT),
    .UPSTREAM_CONNECT_EN_OUT(UPSTREAM_CONNECT_EN_OUT),
    .BATTERY_CHARGE_EN_OUT(BATTERY_CHARGE_EN_OUT),
    .INDIVIDUAL_POWER_OUT(INDIVIDUAL_POWER_OUT)
);
`default_nettype wire

//--- hcs_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the register port; moves only on falling edges
module hcs_host
(
    input wire logic CLK_IN,
    input wire logic [7:0] RDATA_IN,
    input wire logic RVALID_IN,
    output logic [7:0] ADDR_OUT = 8'h00,
    output logic [7:0] WDATA_OUT = 8'h00,
    output logic WR_OUT = 1'b0,
    output logic RD_OUT = 1'b0
);
    // Idle bus shows the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK_IN);
        {ADDR_OUT, WDATA_OUT, WR_OUT} = {a, d, 1'b1};
        @(negedge CLK_IN);
        {ADDR_OUT, WDATA_OUT, WR_OUT} = {~a, ~d, 1'b0};
    endtask
    // No answer means unknown data for the caller
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge CLK_IN);
        {ADDR_OUT, RD_OUT} = {a, 1'b1};
        @(negedge CLK_IN);
        {ADDR_OUT, RD_OUT} = {~a, 1'b0};
        d = RVALID_IN ? RDATA_IN : 8'hxx;
    endtask
    task automatic end_config;
        wr(8'hf8, 8'h01);
    endtask
endmodule
`default_nettype wire

//--- hub_config_status_command_test.sv
`timescale 1ns/10ps
`default_nettype none
// ----------
// Bench
// ----------
module hub_config_status_command_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enter = 1'b0;
    logic pol = 1'b1;
    logic [3:0] batt = 4'ha;
    logic [3:0] req = 4'h5;
    logic gang = 1'b0;
    logic mgmt_n = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, rvalid, conn, reload, indiv, full;
    logic [3:0] pwr, batt_en;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    bit hung = 1'b0;
    hcs_top i_hcs_top (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .CFG_MODE_ENTER_IN(enter), .SHARED_POWER_SWITCH_SEL_IN(gang),
        .PORT_POWER_MGMT_N_IN(mgmt_n), .BATTERY_CHARGE_STRAP_IN(batt),
        .POWER_ENABLE_POLARITY_IN(pol), .PORT_POWER_REQ_IN(req),
        .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .UPSTREAM_CONNECT_EN_OUT(conn), .CFG_RELOAD_OUT(reload),
        .PORT_POWER_ENABLE_OUT(pwr), .BATTERY_CHARGE_EN_OUT(batt_en),
        .INDIVIDUAL_POWER_OUT(indiv), .FULL_POWER_MGMT_OUT(full));
    hcs_host i_hcs_host (.CLK_IN(clk), .RDATA_IN(rdata), .RVALID_IN(rvalid),
        .ADDR_OUT(addr), .WDATA_OUT(wdata), .WR_OUT(wr), .RD_OUT(rd));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset;
        @(negedge clk);
        chk8({2'h0, indiv, full, pwr}, 8'h35);
        chk8({4'h0, batt_en}, 8'h0a);
        i_hcs_host.rd(8'hf8, d);
        chk8(d, 8'h00);
        chk8({7'h0, conn}, 8'h01);
        $display("reset test done");
    endtask
    task automatic t_rsvd;
        i_hcs_host.wr(8'hf8, 8'hfc);
        i_hcs_host.rd(8'hf8, d);
        chk8(d, 8'h00);
        i_hcs_host.rd(8'h00, d);
        chk8(d, 8'h00);
        $display("reserved test done");
    endtask
    task automatic t_cfg;
        @(negedge clk);
        enter = 1'b1;
        @(negedge clk);
        enter = 1'b0;
        chk8({7'h0, conn}, 8'h00);
        i_hcs_host.wr(8'hf8, 8'h00);
        i_hcs_host.rd(8'hf8, d);
        chk8(d, 8'h01);
        i_hcs_host.end_config();
        chk8({7'h0, conn}, 8'h01);
        $display("config test done");
    endtask
    // Strap polarity flips first, so the reload must resample it
    task automatic t_soft;
        pol = 1'b0;
        i_hcs_host.wr(8'hf8, 8'h02);
        chk8({reload, indiv, batt_en, 2'h0}, 8'h80);
        i_hcs_host.rd(8'hf8, d);
        chk8(d, 8'h02);
        n = 2;
        while (reload && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        chk8(8'(n), 8'h04);
        // A reload that never ends is already a mismatch; skip the rest
        if (n >= 20)
        begin
            hung = 1'b1;
            return;
        end
        i_hcs_host.rd(8'hf8, d);
        chk8(d, 8'h00);
        chk8({2'h0, indiv, full, pwr}, 8'h3a);
        $display("soft reset test done");
    endtask
    // Mid-run resets take the straps again: shared_power_switch_sel, then unmanaged
    task automatic t_straps;
        @(negedge clk);
        rst = 1'b1;
        {gang, mgmt_n, pol, req} = {1'b1, 1'b0, 1'b1, 4'h0};
        @(negedge clk);
        chk8({conn, reload, indiv, full, pwr}, 8'h00);
        rst = 1'b0;
        @(negedge clk);
        chk8({2'h0, indiv, full, pwr}, 8'h10);
        req = 4'h2;
        @(negedge clk);
        chk8({4'h0, pwr}, 8'h0f);
        rst = 1'b1;
        {gang, mgmt_n, pol, req, batt} = {1'b0, 1'b1, 1'b0, 4'h0, 4'h5};
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk8({2'h0, indiv, full, pwr}, 8'h20);
        chk8({4'h0, batt_en}, 8'h05);
        chk8({7'h0, conn}, 8'h01);
        $display("straps test done");
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_rsvd();
        t_cfg();
        t_soft();
        if (!hung)
            t_straps();
        summarize();
    end
endmodule
`default_nettype wire
